// File: pts_core.sv
// Privileged processor-state and trap-state registers with trap stack
`timescale 1ns/1ps
module pts_core (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Privileged register access
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [2:0]  reg_sel_i,
    input  wire logic [63:0] wr_data_i,
    output logic      [63:0] rd_data_o,
    output logic             illegal_opcode_trap_o,
    // Trap entry and return
    input  wire logic        trap_take_i,
    input  wire logic [8:0]  trap_type_i,
    input  wire logic [63:0] cur_pc_i,
    input  wire logic [63:0] cur_npc_i,
    input  wire logic        trap_return_i,
    input  wire logic [11:0] stacked_pstate_i,
    // Floating point and interrupt qualification
    input  wire logic        fp_insn_i,
    input  wire logic        fpu_enable_user_i,
    output logic             fpu_disabled_trap_o,
    input  wire logic [3:0]  irq_level_i,
    output logic             irq_accept_o,
    // Address masking
    input  wire logic [63:0] data_addr_i,
    input  wire logic        phys_space_i,
    output logic      [63:0] data_addr_o,
    input  wire logic [63:0] fetch_addr_i,
    output logic      [63:0] fetch_addr_o,
    input  wire logic [63:0] link_pc_i,
    output logic      [63:0] link_pc_o,
    // State word views
    output logic      [11:0] pstate_o,
    output logic      [2:0]  trap_level_o,
    output logic      [1:0]  memory_ordering_model_o,
    output logic             load_pass_store_ok_o,
    output logic             store_reorder_ok_o,
    output logic             load_reorder_ok_o,
    output logic             privileged_mode_o,
    output logic      [1:0]  global_set_o
);

    logic [11:0] pstate;
    logic [2:0]  trap_level;
    logic [3:0]  irq_thresh;
    logic [63:0] trap_saved_pc      [1:pts_pkg::MAX_LEVEL];
    logic [63:0] trap_saved_next_pc [1:pts_pkg::MAX_LEVEL];
    logic [2:0]  next_level;
    logic [2:0]  wr_level_val;
    logic        level_zero;
    logic        stack_sel;
    logic        gsel_bad;
    logic        wr_ok;
    logic [11:0] next_pstate_trap;
    logic        addr_mask;

    assign level_zero = (trap_level == 3'h0);
    assign stack_sel  = (reg_sel_i == pts_pkg::REG_SAVED_PC)
                     || (reg_sel_i == pts_pkg::REG_SAVED_NPC);
    // More than one of the three global selects set
    assign gsel_bad  = (wr_data_i[pts_pkg::PS_ALT_G] & wr_data_i[pts_pkg::PS_INT_G])
                     | (wr_data_i[pts_pkg::PS_ALT_G] & wr_data_i[pts_pkg::PS_MMU_G])
                     | (wr_data_i[pts_pkg::PS_INT_G] & wr_data_i[pts_pkg::PS_MMU_G]);

    always_comb begin
        illegal_opcode_trap_o = 1'b0;
        if ((wr_en_i || rd_en_i) && stack_sel && level_zero) begin
            illegal_opcode_trap_o = 1'b1; // RQ20 RQ22
        end
        if (wr_en_i && (reg_sel_i == pts_pkg::REG_PSTATE) && gsel_bad) begin
            illegal_opcode_trap_o = 1'b1; // RQ24
        end
    end

    // Writes are dropped when they raise the illegal opcode trap
    assign wr_ok = wr_en_i && !illegal_opcode_trap_o && !trap_take_i;

    assign wr_level_val = (wr_data_i > 64'(pts_pkg::MAX_LEVEL)) ? pts_pkg::MAX_LEVEL_VAL
                                                                : wr_data_i[2:0]; // RQ17
    assign next_level   = (trap_level == pts_pkg::MAX_LEVEL_VAL) ? trap_level
                                                                 : trap_level + 3'h1; // RQ25

    // Global select and flag updates on trap entry
    always_comb begin
        next_pstate_trap = pstate;
        next_pstate_trap[pts_pkg::PS_CUR_LE]   = pstate[pts_pkg::PS_TRAP_LE];
        next_pstate_trap[pts_pkg::PS_PRIVMODE] = 1'b1;
        next_pstate_trap[pts_pkg::PS_IRQ_EN]   = 1'b0;
        next_pstate_trap[pts_pkg::PS_ALT_G]    = 1'b0;
        next_pstate_trap[pts_pkg::PS_INT_G]    = 1'b0;
        next_pstate_trap[pts_pkg::PS_MMU_G]    = 1'b0;
        if (trap_type_i == pts_pkg::TT_IVEC) begin
            next_pstate_trap[pts_pkg::PS_INT_G] = 1'b1; // RQ23
        end else if ((trap_type_i >= pts_pkg::TT_MMU_LO && trap_type_i <= pts_pkg::TT_MMU_HI)
                     || trap_type_i == pts_pkg::TT_DAX || trap_type_i == pts_pkg::TT_IAX) begin
            next_pstate_trap[pts_pkg::PS_MMU_G] = 1'b1; // RQ23
        end else begin
            next_pstate_trap[pts_pkg::PS_ALT_G] = 1'b1; // RQ13 RQ14
        end
        if (trap_level == pts_pkg::FLAG_SET_LEVEL) begin
            next_pstate_trap[pts_pkg::PS_ERR_FLAG] = 1'b1; // RQ5
        end
    end

    // Processor state word; trap entry takes priority over a write
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pstate <= pts_pkg::RESET_PSTATE; // RQ5
        end else if (trap_take_i) begin
            pstate <= next_pstate_trap;
        end else if (trap_return_i) begin
            pstate <= stacked_pstate_i; // RQ6
        end else if (wr_ok && reg_sel_i == pts_pkg::REG_PSTATE) begin
            // Takes effect at this edge so the next instruction sees it
            pstate <= wr_data_i[11:0]; // RQ6 RQ7
        end
    end

    // Trap level register
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trap_level <= pts_pkg::RESET_LEVEL; // RQ16
        end else if (trap_take_i) begin
            trap_level <= next_level; // RQ25
        end else if (trap_return_i) begin
            trap_level <= level_zero ? trap_level : trap_level - 3'h1;
        end else if (wr_ok && reg_sel_i == pts_pkg::REG_LEVEL) begin
            trap_level <= wr_level_val; // RQ15 RQ18
        end
    end

    // Interrupt level threshold
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_thresh <= pts_pkg::RESET_THRESHOLD;
        end else if (wr_ok && reg_sel_i == pts_pkg::REG_THRESH) begin
            irq_thresh <= wr_data_i[3:0];
        end
    end

    // Saved pc stacks: no reset, contents undefined after power-on
    genvar lv;
    generate
        for (lv = 1; lv <= pts_pkg::MAX_LEVEL; lv++) begin : g_stack
            always_ff @(posedge mclk_i) begin
                if (trap_take_i && next_level == 3'(lv)) begin
                    trap_saved_pc[lv]      <= {(addr_mask ? 32'h0000_0000 : cur_pc_i[63:32]),
                                               cur_pc_i[31:2], 2'h0}; // RQ9 RQ21 RQ25
                    trap_saved_next_pc[lv] <= {(addr_mask ? 32'h0000_0000 : cur_npc_i[63:32]),
                                               cur_npc_i[31:0]}; // RQ9 RQ25
                end else if (wr_ok && trap_level == 3'(lv)) begin
                    if (reg_sel_i == pts_pkg::REG_SAVED_PC) begin
                        trap_saved_pc[lv] <= {wr_data_i[63:2], 2'h0}; // RQ20 RQ21
                    end
                    if (reg_sel_i == pts_pkg::REG_SAVED_NPC) begin
                        trap_saved_next_pc[lv] <= wr_data_i; // RQ22
                    end
                end
            end
        end
    endgenerate

    // Read data held in a flip-flop, one cycle after the read
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 64'h0000_0000_0000_0000;
        end else if (rd_en_i && !illegal_opcode_trap_o) begin
            unique case (reg_sel_i)
                pts_pkg::REG_PSTATE: rd_data_o <= {52'h0_0000_0000_0000, pstate};
                pts_pkg::REG_LEVEL:     rd_data_o <= {61'h0, trap_level};
                pts_pkg::REG_THRESH:    rd_data_o <= {60'h0, irq_thresh};
                pts_pkg::REG_SAVED_PC:  rd_data_o <= trap_saved_pc[trap_level]; // RQ20
                pts_pkg::REG_SAVED_NPC: rd_data_o <= trap_saved_next_pc[trap_level]; // RQ22
                default:                rd_data_o <= 64'h0000_0000_0000_0000;
            endcase
        end
    end

    assign addr_mask = pstate[pts_pkg::PS_ADDR_MSK];

    assign data_addr_o  = (addr_mask && !phys_space_i) ? {32'h0000_0000, data_addr_i[31:0]}
                                                       : data_addr_i; // RQ9 RQ10
    assign fetch_addr_o = addr_mask ? {32'h0000_0000, fetch_addr_i[31:0]}
                                    : fetch_addr_i; // RQ9
    assign link_pc_o    = addr_mask ? {32'h0000_0000, link_pc_i[31:0]} : link_pc_i; // RQ9

    assign fpu_disabled_trap_o = fp_insn_i &&
                                 !(pstate[pts_pkg::PS_FPU_EN] && fpu_enable_user_i); // RQ8
    // Level 15 is maskable like any other
    assign irq_accept_o = pstate[pts_pkg::PS_IRQ_EN] && (irq_level_i > irq_thresh); // RQ11 RQ19

    assign pstate_o                = pstate;
    assign trap_level_o            = trap_level;
    assign privileged_mode_o       = pstate[pts_pkg::PS_PRIVMODE]; // RQ11
    assign memory_ordering_model_o = pstate[pts_pkg::PS_ORDER +: 2];

    // Reordering permissions for the load-store unit; reserved value treated as strongest
    always_comb begin
        load_pass_store_ok_o = 1'b0;
        store_reorder_ok_o   = 1'b0;
        load_reorder_ok_o    = 1'b0;
        unique case (pts_pkg::pts_mm_t'(pstate[pts_pkg::PS_ORDER +: 2]))
            pts_pkg::PTS_TOTAL_ORDER: load_pass_store_ok_o = 1'b1; // RQ2
            pts_pkg::PTS_PARTIAL_ORDER: begin
                load_pass_store_ok_o = 1'b1; // RQ3
                store_reorder_ok_o   = 1'b1;
            end
            pts_pkg::PTS_RELAXED_ORDER: begin
                load_pass_store_ok_o = 1'b1; // RQ4
                store_reorder_ok_o   = 1'b1;
                load_reorder_ok_o    = 1'b1;
            end
            pts_pkg::PTS_RSV: load_pass_store_ok_o = 1'b0;
        endcase
    end

    // Register numbers 0-7 select this set
    always_comb begin
        if (pstate[pts_pkg::PS_ALT_G]) begin
            global_set_o = pts_pkg::PTS_G_ALT; // RQ12
        end else if (pstate[pts_pkg::PS_INT_G]) begin
            global_set_o = pts_pkg::PTS_G_INTR;
        end else if (pstate[pts_pkg::PS_MMU_G]) begin
            global_set_o = pts_pkg::PTS_G_MMU;
        end else begin
            global_set_o = pts_pkg::PTS_G_NORMAL; // RQ12
        end
    end

endmodule

// File: pts_pkg.sv
// Constants and types for the privileged processor-state and trap-state block
// How it works
// RQ1 - Software never writes ordering model value 11
// RQ2 - Total store order: only loads pass stores
// RQ3 - Partial store order: stores reorder without barrier
// RQ4 - Relaxed order: any order, barriers impose it
// RQ5 - Reset or trap at level four sets flag
// RQ6 - Return restores stacked state; write clears flag
// RQ7 - Flag write visible to very next instruction
// RQ8 - Floating point traps unless both enables set
// RQ9 - Address mask zeroes upper 32 address bits
// RQ10 - Physical space accesses ignore address mask
// RQ11 - Privileged flag sets mode; enable gates interrupts
// RQ12 - Register numbers 0-7 map by global selects
// RQ13 - Ordinary traps select alternate globals only
// RQ14 - At most one global select bit set
// RQ15 - Trap level spans zero to five
// RQ16 - Power-on reset loads trap level five
// RQ17 - Writes above five store five
// RQ18 - Trap level write changes nothing else
// RQ19 - Accept interrupts only above threshold level
// RQ20 - Saved pc per level; level zero traps
// RQ21 - Saved pc low two bits read zero
// RQ22 - Saved next pc per level; level zero traps
// RQ23 - Interrupt and MMU traps pick their globals
// RQ24 - State write with several selects traps
// RQ25 - Trap entry raises level, captures pc pair
package pts_pkg;

    localparam int          MAX_LEVEL       = 5;
    localparam logic [2:0]  MAX_LEVEL_VAL   = 3'h5;
    localparam logic [2:0]  RESET_LEVEL     = 3'h5;
    localparam logic [2:0]  FLAG_SET_LEVEL  = 3'h4;
    localparam logic [3:0]  RESET_THRESHOLD = 4'h0;
    // Privileged and error flag set after reset
    localparam logic [11:0] RESET_PSTATE    = 12'h0_024;

    // State word field positions
    localparam int PS_ALT_G    = 0;
    localparam int PS_IRQ_EN   = 1;
    localparam int PS_PRIVMODE = 2;
    localparam int PS_ADDR_MSK = 3;
    localparam int PS_FPU_EN   = 4;
    localparam int PS_ERR_FLAG = 5;
    localparam int PS_ORDER    = 6;
    localparam int PS_TRAP_LE  = 8;
    localparam int PS_CUR_LE   = 9;
    localparam int PS_MMU_G    = 10;
    localparam int PS_INT_G    = 11;

    // Privileged register selectors
    localparam logic [2:0] REG_PSTATE    = 3'h0;
    localparam logic [2:0] REG_LEVEL     = 3'h1;
    localparam logic [2:0] REG_THRESH    = 3'h2;
    localparam logic [2:0] REG_SAVED_PC  = 3'h3;
    localparam logic [2:0] REG_SAVED_NPC = 3'h4;

    // Trap types with their own global set
    localparam logic [8:0] TT_IVEC     = 9'h0_060;
    localparam logic [8:0] TT_DAX      = 9'h0_030;
    localparam logic [8:0] TT_IAX      = 9'h0_008;
    localparam logic [8:0] TT_MMU_LO   = 9'h0_064;
    localparam logic [8:0] TT_MMU_HI   = 9'h0_06F;

    typedef enum logic [1:0] {
        PTS_TOTAL_ORDER   = 2'h0,
        PTS_PARTIAL_ORDER = 2'h1,
        PTS_RELAXED_ORDER = 2'h2,
        PTS_RSV           = 2'h3
    } pts_mm_t;

    typedef enum logic [1:0] {
        PTS_G_NORMAL = 2'h0,
        PTS_G_ALT    = 2'h1,
        PTS_G_INTR   = 2'h2,
        PTS_G_MMU    = 2'h3
    } pts_gset_t;

endpackage

// File: pts_core_sva.sv
// Concurrent checks on the privileged state block ports
`timescale 1ns/1ps
module pts_core_sva (
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic        wr_en_i,
    input wire logic        rd_en_i,
    input wire logic [2:0]  reg_sel_i,
    input wire logic [63:0] wr_data_i,
    input wire logic        illegal_opcode_trap_o,
    input wire logic        trap_take_i,
    input wire logic [8:0]  trap_type_i,
    input wire logic        trap_return_i,
    input wire logic        fp_insn_i,
    input wire logic        fpu_enable_user_i,
    input wire logic        fpu_disabled_trap_o,
    input wire logic [63:0] data_addr_i,
    input wire logic        phys_space_i,
    input wire logic [63:0] data_addr_o,
    input wire logic [11:0] pstate_o,
    input wire logic [2:0]  trap_level_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic wr_lvl;
    logic plain;
    assign wr_lvl = wr_en_i && reg_sel_i == 3'h1 && !trap_take_i && !trap_return_i;
    // Interrupt and mmu trap families pick their own globals
    assign plain = !(trap_type_i inside {[9'h064:9'h06F], 9'h030, 9'h008, 9'h060});
    property p_sat; wr_lvl && wr_data_i > 64'h5 |=> trap_level_o == 3'h5; endproperty
    a_sat: assert property (p_sat) else $error("level not saturated");
    property p_only; wr_lvl |=> pstate_o == $past(pstate_o); endproperty
    a_only: assert property (p_only) else $error("level write moved state");
    property p_one; $countones({pstate_o[11], pstate_o[10], pstate_o[0]}) <= 1; endproperty
    a_one: assert property (p_one) else $error("several global selects");
    property p_bad; wr_en_i && reg_sel_i == 3'h0
        && $countones({wr_data_i[11], wr_data_i[10], wr_data_i[0]}) > 1
        |-> illegal_opcode_trap_o; endproperty
    a_bad: assert property (p_bad) else $error("bad select write not refused");
    property p_stk; (rd_en_i || wr_en_i) && reg_sel_i inside {3'h3, 3'h4}
        && trap_level_o == 3'h0 |-> illegal_opcode_trap_o; endproperty
    a_stk: assert property (p_stk) else $error("stack access at level zero");
    property p_fp; fp_insn_i |-> fpu_disabled_trap_o == !(pstate_o[4] && fpu_enable_user_i);
    endproperty
    a_fp: assert property (p_fp) else $error("fp trap wrong");
    property p_mask; data_addr_o == ((phys_space_i || !pstate_o[3]) ? data_addr_i
        : {32'h0000_0000, data_addr_i[31:0]}); endproperty
    a_mask: assert property (p_mask) else $error("address mask wrong");
    property p_red; trap_take_i && trap_level_o == 3'h4 |=> pstate_o[5]; endproperty
    a_red: assert property (p_red) else $error("flag clear after deep trap");
    property p_alt; trap_take_i && plain |=> pstate_o[0] && !pstate_o[10] && !pstate_o[11];
    endproperty
    a_alt: assert property (p_alt) else $error("alternate globals not chosen");
endmodule
bind pts_core pts_core_sva u_sva (.*);

// File: tb_top.sv
// Directed bench for the privileged state block
`timescale 1ns/1ps
module tb_top;
    logic        mclk_i, sys_rst_i, wr_en_i, rd_en_i, trap_take_i, trap_return_i;
    logic        fp_insn_i, fpu_enable_user_i, phys_space_i, illegal_opcode_trap_o;
    logic        fpu_disabled_trap_o, irq_accept_o, load_pass_store_ok_o;
    logic        store_reorder_ok_o, load_reorder_ok_o, privileged_mode_o;
    logic [1:0]  memory_ordering_model_o, global_set_o;
    logic [2:0]  reg_sel_i, trap_level_o;
    logic [3:0]  irq_level_i;
    logic [8:0]  trap_type_i;
    logic [11:0] stacked_pstate_i, pstate_o;
    logic [63:0] wr_data_i, cur_pc_i, cur_npc_i, data_addr_i, fetch_addr_i, link_pc_i;
    logic [63:0] rd_data_o, data_addr_o, fetch_addr_o, link_pc_o;
    int          errors, compares;
    pts_core DUT (.*);
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Refusal flag is combinational, so it is judged mid-cycle
    task automatic acc(input logic w, input logic [2:0] s, input logic [63:0] d, input logic ill);
        wr_en_i <= w;
        rd_en_i <= !w;
        reg_sel_i <= s;
        wr_data_i <= d;
        @(negedge mclk_i) chk(illegal_opcode_trap_o, ill);
        @(posedge mclk_i);
        wr_en_i <= 1'b0;
        rd_en_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic trap(input logic [8:0] t, input logic [63:0] pc);
        trap_take_i <= 1'b1;
        trap_type_i <= t;
        cur_pc_i <= pc;
        cur_npc_i <= ~pc;
        @(posedge mclk_i);
        trap_take_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic t_level;
        chk(pstate_o, 12'h024);
        chk(trap_level_o, 3'h5);
        chk(privileged_mode_o, 1'b1);
        acc(1'b1, 3'h1, 64'h9, 1'b0);
        chk(trap_level_o, 3'h5);
        acc(1'b1, 3'h1, 64'h0, 1'b0);
        chk(trap_level_o, 3'h0);
        chk(pstate_o, 12'h024);
        acc(1'b0, 3'h3, 64'h0, 1'b1);
        acc(1'b1, 3'h4, 64'h0, 1'b1);
        acc(1'b1, 3'h0, 64'h4, 1'b0);
        chk(pstate_o[5], 1'b0);
    endtask
    task automatic t_trap;
        logic [8:0]  tt[6] = '{9'h041, 9'h060, 9'h030, 9'h064, 9'h06F, 9'h008};
        logic [2:0]  gs[6] = '{3'h1, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2};
        logic [63:0] pc;
        for (int i = 0; i < 6; i++) begin
            pc = 64'h8000_0000_1234_5673 + 64'h10 * i;
            trap(tt[i], pc);
            chk(trap_level_o, (i < 5) ? i + 1 : 5);
            chk({pstate_o[11], pstate_o[10], pstate_o[0]}, gs[i]);
            chk(global_set_o, (gs[i] == 3'h1) ? 2'h1 : 2'h3 - gs[i][2]);
            chk(pstate_o[5], i >= 4);
            acc(1'b0, 3'h3, 64'h0, 1'b0);
            chk(rd_data_o, pc & ~64'h3);
            acc(1'b0, 3'h4, 64'h0, 1'b0);
            chk(rd_data_o, ~pc);
        end
        trap_return_i <= 1'b1;
        stacked_pstate_i <= 12'h004;
        @(posedge mclk_i);
        trap_return_i <= 1'b0;
        @(posedge mclk_i);
        chk(pstate_o, 12'h004);
    endtask
    task automatic t_modes;
        logic [2:0] ord[3] = '{3'h4, 3'h6, 3'h7};
        logic [3:0] lv[3] = '{4'h5, 4'h6, 4'hF};
        acc(1'b1, 3'h0, 64'h405, 1'b1);
        chk(pstate_o, 12'h004);
        for (int m = 0; m < 3; m++) begin
            acc(1'b1, 3'h0, 64'h4 | (m << 6), 1'b0);
            chk(memory_ordering_model_o, m);
            chk({load_pass_store_ok_o, store_reorder_ok_o, load_reorder_ok_o}, ord[m]);
        end
        fp_insn_i <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            fpu_enable_user_i <= k[0];
            acc(1'b1, 3'h0, 64'h4 | (k[1] << 4), 1'b0);
            chk(fpu_disabled_trap_o, k != 3);
        end
        acc(1'b1, 3'h2, 64'h5, 1'b0);
        acc(1'b1, 3'h0, 64'h6, 1'b0);
        foreach (lv[j]) begin
            irq_level_i <= lv[j];
            @(negedge mclk_i) chk(irq_accept_o, j > 0);
            @(posedge mclk_i);
        end
        acc(1'b1, 3'h0, 64'hC, 1'b0);
        chk(irq_accept_o, 1'b0);
        data_addr_i <= '1;
        fetch_addr_i <= '1;
        link_pc_i <= '1;
        @(negedge mclk_i) chk(data_addr_o, 64'h0000_0000_FFFF_FFFF);
        chk(fetch_addr_o, 64'h0000_0000_FFFF_FFFF);
        chk(link_pc_o, 64'h0000_0000_FFFF_FFFF);
        @(posedge mclk_i);
        phys_space_i <= 1'b1;
        @(negedge mclk_i) chk(data_addr_o, '1);
    endtask
    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        {wr_en_i, rd_en_i, trap_take_i, trap_return_i, fp_insn_i, fpu_enable_user_i} = '0;
        {phys_space_i, reg_sel_i, irq_level_i, trap_type_i, stacked_pstate_i} = '0;
        {wr_data_i, cur_pc_i, cur_npc_i, data_addr_i, fetch_addr_i, link_pc_i} = '0;
        sys_rst_i = 1'b1;
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        t_level();
        t_trap();
        t_modes();
        report_and_stop();
    end
endmodule
